//--- common/wdrs_pkg.sv
// Package of constants and types for the watchdog and reset supervisor.
package wdrs_pkg;

    // ------------------------------------------------------------------
    // Register map (printed index, byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [15:0] STATUS_FLAGS_IDX     = 16'h1ff0;
    localparam logic [15:0] WATCHDOG_CONTROL_IDX = 16'h1ff7;
    localparam logic [15:0] SUPERVISOR_CFG_IDX   = 16'h2000;
    localparam logic [31:0] STATUS_FLAGS_ADDR    = 32'h00007fc0;
    localparam logic [31:0] WATCHDOG_CONTROL_ADDR = 32'h00007fdc;
    localparam logic [31:0] SUPERVISOR_CFG_ADDR  = 32'h00008000;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned FLAG_WDF_BIT = 7;
    localparam int unsigned FLAG_BL_BIT  = 4;
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [5:0]  CFG_RESET    = 6'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint CLK_HZ         = 125000000;
    localparam longint OSC_HZ         = 32768;
    localparam longint RST_PULSE_MS   = 40;
    localparam longint RST_PULSE_MAX_MS = 200;
    localparam longint SLOW_DLY_MS    = 20;
    localparam longint SLOW_DLY_MAX_MS = 100;
    localparam longint FAST_DLY_NS    = 50;
    localparam longint FAST_DLY_MAX_NS = 200;
    // Least times round up to whole cycles.
    localparam longint RST_PULSE_CYC  =
        (RST_PULSE_MS * CLK_HZ + 999) / 1000;
    localparam longint SLOW_DLY_CYC   =
        (SLOW_DLY_MS * CLK_HZ + 999) / 1000;
    localparam longint FAST_DLY_CYC   =
        (FAST_DLY_NS * CLK_HZ + 999999999) / 1000000000;
    // Clock cycles per oscillator tick, nearest whole count.
    localparam longint OSC_DIV_CYC    = (CLK_HZ + OSC_HZ / 2) / OSC_HZ;
    // Oscillator ticks per resolution step.
    localparam logic [21:0] RES_TICKS_16TH = 22'h000800;
    localparam logic [21:0] RES_TICKS_QTR  = 22'h002000;
    localparam logic [21:0] RES_TICKS_ONE  = 22'h008000;
    localparam logic [21:0] RES_TICKS_FOUR = 22'h020000;
    // Tick-counter bit that toggles at 512 Hz.
    localparam int unsigned FT_PHASE_BIT = 5;

    // ------------------------------------------------------------------
    // Carried groups
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       watchdog_steering;
        logic [4:0] timeout_multiplier;
        logic [1:0] timeout_resolution;
    } wdrs_ctrl_t;

    typedef struct packed {
        logic clock_read_hold;
        logic clock_write_hold;
        logic osc_stop;
        logic alarm_battery_enable;
        logic alarm_flag_enable;
        logic freq_test_enable;
    } wdrs_cfg_t;

endpackage

//--- core/wdrs_watchdog_supervisor.sv
// Watchdog timer and reset supervisor with an AHB-Lite register slave.
//
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ns
module wdrs_watchdog_supervisor
    import wdrs_pkg::*;
#(
    parameter int unsigned OSC_DIV   = int'(OSC_DIV_CYC),
    parameter int unsigned PULSE_CYC = int'(RST_PULSE_CYC),
    parameter int unsigned SLOW_CYC  = int'(SLOW_DLY_CYC)
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        watchdogKickInput,
    input  wire logic        fastResetInputN,
    input  wire logic        slowResetInputN,
    input  wire logic        batteryLow,
    input  wire logic        resetOutIn,
    output logic             resetOutOut,
    output logic             resetOutOe,
    input  wire logic        irqFreqTestIn,
    output logic             irqFreqTestOut,
    output logic             irqFreqTestOe
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    generate
        if (OSC_DIV < 2 || OSC_DIV > 65535) begin : gBadDiv
            $error("OSC_DIV must lie between 2 and 65535");
        end
        if (PULSE_CYC < 1 || SLOW_CYC < 1) begin : gBadCnt
            $error("PULSE_CYC and SLOW_CYC must be at least one");
        end
    endgenerate

    localparam logic [15:0] OSC_DIV_LAST = 16'(OSC_DIV - 1);
    localparam logic [31:0] PULSE_LOAD   = 32'(PULSE_CYC);
    localparam logic [31:0] SLOW_LAST    = 32'(SLOW_CYC);
    localparam logic [7:0]  FAST_LAST    = 8'(FAST_DLY_CYC);

    // Ticks per resolution step, selected by the resolution code.
    function automatic logic [21:0] resTicks(input logic [1:0] res);
        logic [21:0] t;
        t = RES_TICKS_16TH;
        case (res)
            2'h0:    t = RES_TICKS_16TH;
            2'h1:    t = RES_TICKS_QTR;
            2'h2:    t = RES_TICKS_ONE;
            2'h3:    t = RES_TICKS_FOUR;
            default: t = RES_TICKS_16TH;
        endcase
        return t;
    endfunction

    // Whole timeout in ticks: multiplier times resolution step.
    function automatic logic [21:0] timeoutTicks(input wdrs_ctrl_t c);
        logic [26:0] p;
        p = 27'(c.timeout_multiplier) * 27'(resTicks(c.timeout_resolution));
        return p[21:0];
    endfunction

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    wdrs_ctrl_t  ctrl_r;
    wdrs_cfg_t   cfg_r;
    logic        wdf_r;
    logic        battLow_r;
    logic        battCaught_r;
    logic        irqWd_r;
    logic [21:0] wdCnt_r;
    logic        kickPrev_r;
    logic [15:0] divCnt_r;
    logic        oscTick;
    logic [5:0]  phase_r;
    logic        wrPend_r;
    logic [31:0] wrAddr_r;
    logic        rdFlags;
    logic        ctrlWrite;
    logic        kickEdge;
    logic        wdActive;
    logic        wdTimeout;
    logic        wdResetReq;
    logic [7:0]  fastLowCnt_r;
    logic [31:0] slowLowCnt_r;
    logic [31:0] holdCnt_r;
    logic        rstAssert;
    logic        ftActive;

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------
    logic addrPhase;
    assign addrPhase = hsel & hready & htrans[1];
    assign rdFlags   = addrPhase & ~hwrite & (haddr == STATUS_FLAGS_ADDR);
    assign ctrlWrite = wrPend_r & (wrAddr_r == WATCHDOG_CONTROL_ADDR);

    // Latch the write address; the data follow in the next cycle.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 32'h00000000;
        end else begin
            wrPend_r <= addrPhase & hwrite;
            if (addrPhase) begin
                wrAddr_r <= haddr;
            end
        end
    end

    // Read data is prepared at the address phase so it stands from a flop.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h00000000;
        end else if (addrPhase && !hwrite) begin
            case (haddr)
                STATUS_FLAGS_ADDR: begin
                    hrdata <= 32'h00000000;
                    hrdata[FLAG_WDF_BIT] <= wdf_r;
                    hrdata[FLAG_BL_BIT]  <= battLow_r;
                end
                WATCHDOG_CONTROL_ADDR: hrdata <= {24'h000000, ctrl_r};
                SUPERVISOR_CFG_ADDR:   hrdata <= {26'h0000000, cfg_r};
                default:               hrdata <= 32'h00000000;
            endcase
        end
    end

    // Zero-wait slave that always answers OKAY.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Configuration register; power-up leaves every enable clear.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_r <= CFG_RESET;
        end else if (wrPend_r && wrAddr_r == SUPERVISOR_CFG_ADDR) begin
            cfg_r <= hwdata[5:0];
        end
    end

    // ------------------------------------------------------------------
    // Oscillator tick and 512 Hz phase
    // ------------------------------------------------------------------
    // The tick stands still while the oscillator is stopped.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            divCnt_r <= 16'h0000;
        end else if (cfg_r.osc_stop) begin
            divCnt_r <= 16'h0000;
        end else if (divCnt_r == OSC_DIV_LAST) begin
            divCnt_r <= 16'h0000;
        end else begin
            divCnt_r <= divCnt_r + 16'h0001;
        end
    end
    assign oscTick = ~cfg_r.osc_stop & (divCnt_r == OSC_DIV_LAST);

    // Free-running tick counter; its top bit flips every 32 ticks.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            phase_r <= 6'h00;
        end else if (oscTick) begin
            phase_r <= phase_r + 6'h01;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog counter
    // ------------------------------------------------------------------
    assign kickEdge  = watchdogKickInput ^ kickPrev_r;
    assign wdActive  = (ctrl_r.timeout_multiplier != 5'h00);
    assign wdTimeout = wdActive & oscTick & (wdCnt_r == 22'h000001);
    assign wdResetReq = wdTimeout & ctrl_r.watchdog_steering;

    // Previous kick level; idles high like the pulled-up pin.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            kickPrev_r <= 1'b1;
        end else begin
            kickPrev_r <= watchdogKickInput;
        end
    end

    // Remaining ticks; zero means the count is not running.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wdCnt_r <= 22'h000000;
        end else if (ctrlWrite) begin
            wdCnt_r <= timeoutTicks(hwdata[7:0]);
        end else if (!wdActive) begin
            wdCnt_r <= 22'h000000;
        end else if (kickEdge) begin
            wdCnt_r <= timeoutTicks(ctrl_r);
        end else if (wdTimeout) begin
            wdCnt_r <= 22'h000000;
        end else if (oscTick && wdCnt_r != 22'h000000) begin
            wdCnt_r <= wdCnt_r - 22'h000001;
        end
    end

    // Control register; a reset-mode timeout clears it, writes win.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= CTRL_RESET;
        end else if (ctrlWrite) begin
            ctrl_r <= hwdata[7:0];
        end else if (wdResetReq) begin
            ctrl_r <= CTRL_RESET;
        end
    end

    // Expired flag: read of the flags register clears, a timeout wins.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wdf_r <= 1'b0;
        end else if (wdTimeout) begin
            wdf_r <= 1'b1;
        end else if (rdFlags) begin
            wdf_r <= 1'b0;
        end
    end

    // Interrupt-mode hold; only a write of zero releases it.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irqWd_r <= 1'b0;
        end else if (wdTimeout && !ctrl_r.watchdog_steering) begin
            irqWd_r <= 1'b1;
        end else if (ctrlWrite && hwdata[7:0] == 8'h00) begin
            irqWd_r <= 1'b0;
        end
    end

    // Battery level is caught once, at the first edge after reset release.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            battLow_r    <= 1'b0;
            battCaught_r <= 1'b0;
        end else if (!battCaught_r) begin
            battLow_r    <= batteryLow;
            battCaught_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Reset output supervisor
    // ------------------------------------------------------------------
    // Count how long each reset input has been held low.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fastLowCnt_r <= 8'h00;
            slowLowCnt_r <= 32'h00000000;
        end else begin
            if (fastResetInputN) begin
                fastLowCnt_r <= 8'h00;
            end else if (fastLowCnt_r != FAST_LAST) begin
                fastLowCnt_r <= fastLowCnt_r + 8'h01;
            end
            if (slowResetInputN) begin
                slowLowCnt_r <= 32'h00000000;
            end else if (slowLowCnt_r != SLOW_LAST) begin
                slowLowCnt_r <= slowLowCnt_r + 32'h00000001;
            end
        end
    end

    assign rstAssert = (fastLowCnt_r == FAST_LAST) |
                       (slowLowCnt_r == SLOW_LAST) |
                       wdResetReq;

    // Hold counter reloads while a source asserts, then runs out.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            holdCnt_r <= 32'h00000000;
        end else if (rstAssert) begin
            holdCnt_r <= PULSE_LOAD;
        end else if (holdCnt_r != 32'h00000000) begin
            holdCnt_r <= holdCnt_r - 32'h00000001;
        end
    end

    // Open-drain reset pin: level stays low, enable pulls it.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            resetOutOut <= 1'b0;
            resetOutOe  <= 1'b0;
        end else begin
            resetOutOut <= 1'b0;
            resetOutOe  <= rstAssert | (holdCnt_r > 32'h00000001);
        end
    end

    // ------------------------------------------------------------------
    // Shared interrupt and frequency-test output
    // ------------------------------------------------------------------
    assign ftActive = cfg_r.freq_test_enable & ~cfg_r.osc_stop &
                      ~cfg_r.alarm_flag_enable & ~irqWd_r &
                      (ctrl_r.watchdog_steering |
                       (ctrl_r == CTRL_RESET));

    // Drive low for the watchdog, or on the low half of the 512 Hz wave.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irqFreqTestOut <= 1'b0;
            irqFreqTestOe  <= 1'b0;
        end else begin
            irqFreqTestOut <= 1'b0;
            irqFreqTestOe  <= irqWd_r |
                              (ftActive & ~phase_r[FT_PHASE_BIT]);
        end
    end

endmodule

//--- dv/wdrs_watchdog_supervisor_properties.sv
// Concurrent checks on the supervisor's pins and register bus.
`timescale 1ns/1ns
module wdrs_watchdog_supervisor_properties
    import wdrs_pkg::*;
#(
    parameter int unsigned PULSE_CYC = 50,
    parameter int unsigned SLOW_CYC  = 20
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic        fastResetInputN,
    input wire logic        slowResetInputN,
    input wire logic        resetOutOut,
    input wire logic        resetOutOe,
    input wire logic        irqFreqTestOut,
    input wire logic        irqFreqTestOe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    logic [7:0]  slowCnt_r;
    logic [31:0] oeCnt_r;
    logic        ctrlWr_r;

    // Counts cycles of a held slow reset input, saturating.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) slowCnt_r <= 8'h00;
        else if (slowResetInputN) slowCnt_r <= 8'h00;
        else if (slowCnt_r != 8'hff) slowCnt_r <= slowCnt_r + 8'h01;
    end

    // Counts how long the reset pin has been pulled low.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) oeCnt_r <= 32'h0;
        else if (!resetOutOe) oeCnt_r <= 32'h0;
        else oeCnt_r <= oeCnt_r + 32'h1;
    end

    // Marks the data phase of a write to the control register.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) ctrlWr_r <= 1'b0;
        else ctrlWr_r <= hsel && hready && htrans[1] && hwrite &&
                         haddr == WATCHDOG_CONTROL_ADDR;
    end

    rst_drain_a: assert property (resetOutOut == 1'b0)
        else $error("Reset pin driven high.");
    irq_drain_a: assert property (irqFreqTestOut == 1'b0)
        else $error("Interrupt pin driven high.");
    fast_hold_a: assert property ($rose(fastResetInputN) && resetOutOe
        |-> resetOutOe[*8]) else $error("Reset released too soon.");
    slow_late_a: assert property ($rose(resetOutOe) && fastResetInputN
        && !slowResetInputN |-> 32'(slowCnt_r) >= SLOW_CYC - 1)
        else $error("Slow reset asserted too early.");
    slow_assert_a: assert property (32'(slowCnt_r) == SLOW_CYC + 3
        |-> resetOutOe) else $error("Slow reset not asserted.");
    pulse_len_a: assert property ($fell(resetOutOe)
        |-> oeCnt_r >= PULSE_CYC) else $error("Reset pulse too short.");
    quiet_start_a: assert property ($rose(resetn)
        |-> !resetOutOe && !irqFreqTestOe) else $error("Pin busy at start.");
    irq_release_a: assert property (ctrlWr_r && hwdata[7:0] == 8'h00
        |-> ##[1:2] !irqFreqTestOe) else $error("Interrupt not released.");

    cover property ($rose(irqFreqTestOe));
    cover property ($fell(resetOutOe));
    cover property (ctrlWr_r);
endmodule

bind wdrs_watchdog_supervisor wdrs_watchdog_supervisor_properties #(
    .PULSE_CYC(PULSE_CYC), .SLOW_CYC(SLOW_CYC)
) props_i (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .fastResetInputN(fastResetInputN), .slowResetInputN(slowResetInputN),
    .resetOutOut(resetOutOut), .resetOutOe(resetOutOe),
    .irqFreqTestOut(irqFreqTestOut), .irqFreqTestOe(irqFreqTestOe)
);

//--- dv/wdrs_host_model.sv
// Host model issuing single-word AHB-Lite transfers.
`timescale 1ns/1ns
module wdrs_host_model (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    int hangs = 0;

    // Bus starts idle with word size.
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // Waits for hready at a rising edge; a slave that never answers is noted.
    task automatic waitReady();
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (n >= 64) hangs++;
    endtask

    // Address phase, then data phase; read data is taken at its last edge.
    task automatic xfer(input logic [31:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= w ? d : ~hwdata;
        waitReady();
        q = hrdata;
        hwdata <= ~hwdata;
    endtask
endmodule

//--- dv/wdrs_watchdog_supervisor_tb.sv
// Self-checking bench for the watchdog and reset supervisor.
`timescale 1ns/1ns
module wdrs_watchdog_supervisor_tb
    import wdrs_pkg::*;
;
    localparam int DIV = 4;
    localparam int PUL = 50;
    localparam int SLW = 20;
    localparam int T16 = int'(RES_TICKS_16TH) * DIV;
    localparam logic [31:0] CTRL = WATCHDOG_CONTROL_ADDR;
    localparam logic [31:0] FLAGS = STATUS_FLAGS_ADDR;
    localparam logic [31:0] CFG = SUPERVISOR_CFG_ADDR;
    logic        clk = 1'b0, resetn = 1'b0, kick = 1'b1, batLow = 1'b1;
    logic        fastN = 1'b1, slowN = 1'b1;
    logic        hsel, hwrite, hreadyout, hresp;
    logic        rstOut, rstOe, irqOut, irqOe;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata;
    int          errors = 0, checks = 0;

    wdrs_watchdog_supervisor #(.OSC_DIV(DIV), .PULSE_CYC(PUL),
        .SLOW_CYC(SLW)) uut (
        .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .watchdogKickInput(kick),
        .fastResetInputN(fastN), .slowResetInputN(slowN),
        .batteryLow(batLow), .resetOutIn(!rstOe), .resetOutOut(rstOut),
        .resetOutOe(rstOe), .irqFreqTestIn(!irqOe),
        .irqFreqTestOut(irqOut), .irqFreqTestOe(irqOe));
    wdrs_host_model host (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    // Free-running 125 MHz clock.
    initial forever #4 clk = ~clk;

    // Compares one value and reports a difference at once.
    task automatic chk(input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        chk(32'(host.hangs), 32'h0);
        $display("Counts: errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [31:0] a, d);
        logic [31:0] q;
        host.xfer(a, 1'b1, d, q);
    endtask

    task automatic rdChk(input logic [31:0] a, exp);
        logic [31:0] q;
        host.xfer(a, 1'b0, 32'h0, q);
        chk(q, exp);
        chk(32'({hreadyout, hresp}), 32'h2);
    endtask

    // Cycles until a pin is pulled low; a required pull that never comes
    // ends the run.
    task automatic waitOe(input bit rst, input int lim, input bit must,
                          output int n);
        n = 0;
        while ((rst ? rstOe : irqOe) !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (must && n >= lim) begin
            errors++;
            stop_test();
        end
    endtask

    // Cycles for which the reset pin stays pulled low.
    task automatic pulseLen(output int n);
        n = 0;
        while (rstOe === 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
    endtask

    // Changes of the shared pin over a fixed window.
    task automatic toggles(output int c);
        logic p;
        idle(4);
        c = 0;
        p = irqOe;
        repeat (1024) begin
            @(posedge clk);
            if (irqOe !== p) c++;
            p = irqOe;
        end
    endtask

    task automatic t_defaults();
        int n;
        rdChk(CTRL, 32'h0);
        rdChk(CFG, 32'h0);
        rdChk(FLAGS, 32'h10);
        wr(32'h00007fc4, 32'hff);
        rdChk(32'h00007fc4, 32'h0);
        wr(CTRL, 32'h80);
        kick <= 1'b0;
        waitOe(1'b1, 3000, 1'b0, n);
        chk(32'(n), 32'd3000);
        chk(32'(irqOe), 32'h0);
    endtask

    task automatic t_timeouts();
        int n, e;
        logic [7:0] v [2] = '{8'h08, 8'h05};
        for (int i = 0; i < 2; i++) begin
            e = (i + 1) * 2 * T16;
            wr(CTRL, 32'(v[i]));
            waitOe(1'b0, e + 64, 1'b1, n);
            chk(32'(n >= e - 8 && n <= e + 8), 32'h1);
            chk(32'(rstOe), 32'h0);
            rdChk(FLAGS, 32'h90);
            rdChk(FLAGS, 32'h10);
            wr(CTRL, 32'(v[i]));
            chk(32'(irqOe), 32'h1);
            wr(CTRL, 32'h0);
            idle(3);
            chk(32'(irqOe), 32'h0);
        end
        for (int i = 6; i < 8; i++) begin
            wr(CTRL, 32'(i));
            waitOe(1'b0, 1500, 1'b0, n);
            chk(32'(n), 32'd1500);
        end
        wr(CTRL, 32'h0);
    endtask

    task automatic t_restart();
        int n;
        wr(CTRL, 32'h04);
        for (int i = 0; i < 3; i++) begin
            idle(5000);
            chk(32'(irqOe), 32'h0);
            if (i == 0) wr(CTRL, 32'h04);
            else kick <= ~kick;
        end
        waitOe(1'b0, T16 + 64, 1'b1, n);
        chk(32'(n >= T16 - 8 && n <= T16 + 8), 32'h1);
        wr(CTRL, 32'h0);
        rdChk(FLAGS, 32'h90);
    endtask

    task automatic t_reset_mode();
        int n;
        wr(CTRL, 32'h84);
        waitOe(1'b1, T16 + 64, 1'b1, n);
        chk(32'(n >= T16 - 8 && n <= T16 + 8), 32'h1);
        pulseLen(n);
        chk(32'(n >= PUL && n <= 5 * PUL), 32'h1);
        chk(32'(irqOe), 32'h0);
        rdChk(CTRL, 32'h0);
        rdChk(FLAGS, 32'h90);
    endtask

    task automatic t_freq();
        int c;
        wr(CFG, 32'h01);
        toggles(c);
        chk(32'(c >= 7 && c <= 9), 32'h1);
        wr(CFG, 32'h03);
        toggles(c);
        chk(32'(c), 32'h0);
        wr(CFG, 32'h01);
        wr(CTRL, 32'h84);
        toggles(c);
        chk(32'(c >= 7 && c <= 9), 32'h1);
        wr(CTRL, 32'h04);
        toggles(c);
        chk(32'(c), 32'h0);
        wr(CFG, 32'h0);
        wr(CTRL, 32'h0);
    endtask

    task automatic t_rst_inputs();
        int n;
        fastN <= 1'b0;
        waitOe(1'b1, 20, 1'b1, n);
        idle(10);
        fastN <= 1'b1;
        pulseLen(n);
        chk(32'(n >= PUL && n <= 5 * PUL), 32'h1);
        slowN <= 1'b0;
        idle(SLW - 4);
        slowN <= 1'b1;
        waitOe(1'b1, 8, 1'b0, n);
        chk(32'(n), 32'd8);
        slowN <= 1'b0;
        waitOe(1'b1, 5 * SLW, 1'b1, n);
        chk(32'(n >= SLW - 1 && n <= 5 * SLW), 32'h1);
        idle(5);
        slowN <= 1'b1;
        pulseLen(n);
        chk(32'(n >= PUL && n <= 5 * PUL), 32'h1);
    endtask

    // Reset, then each scenario in turn.
    initial begin
        idle(10);
        resetn <= 1'b1;
        @(posedge clk);
        t_defaults();
        t_timeouts();
        t_restart();
        t_reset_mode();
        t_freq();
        t_rst_inputs();
        stop_test();
    end
endmodule
